// File: rtl/mcst_clock_top.sv
// clock source selection, PLL gating, slow divider, trim registers
`timescale 1ns/100ps
`include "mcst_params.svh"
module mcst_clock_top (
   input  wire logic                clock,          // 25 MHz system clock
   input  wire logic                rst,            // sync reset, high
   input  wire mcst_pkg::mcst_opt_t opt,            // option byte fields
   input  wire logic                wake_halt,      // wake or auto-wake pulse
   input  wire logic                rc_tick,        // 1 MHz RC enable
   input  wire logic                xtal_tick,      // crystal enable
   input  wire logic                ext_clock_in,   // ext clock enable
   input  wire logic                psel,           // apb select
   input  wire logic                penable,        // apb enable
   input  wire logic                pwrite,         // apb write
   input  wire logic [11:0]         paddr,          // apb address
   input  wire logic [31:0]         pwdata,         // apb write data
   output logic      [31:0]         prdata,         // apb read data
   output logic                     pready,         // apb ready
   output logic                     pslverr,        // apb error
   output logic                     osc_tick,       // oscillator clock enable
   output logic                     cpu_tick,       // cpu clock enable
   output logic                     clk_out_pin,    // clock out pin level
   output logic                     clk_out_oe,     // clock out drive
   output logic                     ext_pin_in_sel, // default pin is ext clock
   output logic                     xtal_run,       // crystal oscillator on
   output logic      [9:0]          rc_trim         // trim code to RC
);
   logic [7:0] main_ctrl_q;
   logic [7:0] trim_upper_q;
   logic [1:0] trim_low_q;
   logic       pll_en;
   logic       pll_run;
   logic       pll_lock;
   logic [7:0] ft_data;
   logic [2:0] pll_ph_q;
   logic       osc_d;
   logic [4:0] div_q;
   logic       slow_q;
   logic       wr;
   logic       rd;

   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign pll_en = opt.pll_factor_option != mcst_pkg::mcst_pll_off;

   mcst_pll_ctrl u_pll (
      .clock  (clock),
      .rst    (rst),
      .enable (pll_en),
      .wake   (wake_halt),
      .run    (pll_run),
      .pll_lock_flag (pll_lock)
   );

   mcst_ftrim_rom u_rom (
      .clock (clock),
      .addr  (paddr[3:2]),
      .rdata (ft_data)
   );

   // control register; bits 7:2 left to software discipline
   always_ff @(posedge clock) begin
      if (rst)
         main_ctrl_q <= `MCST_MAIN_CTRL_RESET;
      else if (wr && paddr == `MCST_OFS_MAIN_CTRL && pready)
         main_ctrl_q <= pwdata[7:0];
   end

   always_ff @(posedge clock) begin
      if (rst)
         trim_upper_q <= `MCST_TRIM_UPPER_RESET;
      else if (wr && paddr == `MCST_OFS_TRIM_UPPER && pready)
         trim_upper_q <= pwdata[7:0];
   end

   always_ff @(posedge clock) begin
      if (rst)
         trim_low_q <= `MCST_TRIM_LOW_RESET;
      else if (wr && paddr == `MCST_OFS_INTEGRITY && pready)
         trim_low_q <= pwdata[`MCST_TRIM_LOW_MSB:`MCST_TRIM_LOW_LSB];
   end

   // higher code means slower RC, passed straight through
   always_ff @(posedge clock) begin
      if (rst)
         rc_trim <= {`MCST_TRIM_UPPER_RESET, `MCST_TRIM_LOW_RESET};
      else
         rc_trim <= {trim_upper_q, trim_low_q};
   end

   // rom read needs one extra cycle, so every access takes two
   always_ff @(posedge clock) begin
      if (rst)
         pready <= 1'b0;
      else
         pready <= psel && penable && !pready;
   end

   always_ff @(posedge clock) begin
      if (rst)
         pslverr <= 1'b0;
      else
         pslverr <= psel && penable && !pready && paddr != `MCST_OFS_MAIN_CTRL
                    && paddr != `MCST_OFS_TRIM_UPPER && paddr != `MCST_OFS_INTEGRITY
                    && paddr != `MCST_OFS_STATUS && paddr[11:4] != 8'(`MCST_OFS_FTRIM >> 4);
   end

   always_ff @(posedge clock) begin
      if (rst)
         prdata <= 32'h0000_0000;
      else if (rd && !pready) begin
         if (paddr == `MCST_OFS_MAIN_CTRL)
            prdata <= {24'h00_0000, main_ctrl_q};
         else if (paddr == `MCST_OFS_TRIM_UPPER)
            prdata <= {24'h00_0000, trim_upper_q};
         else if (paddr == `MCST_OFS_INTEGRITY)
            prdata <= {25'h000_0000, trim_low_q, 5'h00};
         else if (paddr == `MCST_OFS_STATUS)
            prdata <= {30'h0000_0000, pll_run, pll_lock};
         else if (paddr[11:4] == 8'(`MCST_OFS_FTRIM >> 4))
            prdata <= {24'h00_0000, ft_data};
         else
            prdata <= 32'h0000_0000;
      end
   end

   // PLL modelled as a phase counter advancing on every system clock
   always_ff @(posedge clock) begin
      if (rst)
         pll_ph_q <= 3'h0;
      else
         pll_ph_q <= pll_ph_q + 3'h1;
   end

   // source mux from option byte
   always_comb begin
      osc_d = 1'b0;
      if (pll_en)
         osc_d = pll_run && (opt.pll_factor_option == mcst_pkg::mcst_pll_x8
                 ? 1'b1 : pll_ph_q[0]);
      else unique case (opt.src)
         mcst_pkg::mcst_src_rc:   osc_d = rc_tick;
         mcst_pkg::mcst_src_xtal: osc_d = xtal_tick;
         default:                 osc_d = ext_clock_in;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst)
         osc_tick <= 1'b0;
      else
         osc_tick <= osc_d;
   end

   // slow mode only changes at divider wrap, so no short pulse
   always_ff @(posedge clock) begin
      if (rst) begin
         div_q  <= 5'h00;
         slow_q <= 1'b0;
      end else if (osc_d) begin
         div_q <= div_q + 5'h01;
         if (div_q == 5'(`MCST_SLOW_DIV - 6'd1))
            slow_q <= main_ctrl_q[`MCST_BIT_SLOW];
         else if (!slow_q)
            slow_q <= main_ctrl_q[`MCST_BIT_SLOW] && div_q == 5'h1F;
      end
   end

   always_ff @(posedge clock) begin
      if (rst)
         cpu_tick <= 1'b0;
      else
         cpu_tick <= osc_d && (!slow_q || div_q == 5'h1F);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         clk_out_pin <= 1'b0;
         clk_out_oe  <= 1'b0;
      end else begin
         clk_out_oe  <= main_ctrl_q[`MCST_BIT_CLKOUT];
         clk_out_pin <= main_ctrl_q[`MCST_BIT_CLKOUT]
                        && osc_d && (!slow_q || div_q == 5'h1F);
      end
   end

   // crystal never stopped by reset
   always_ff @(posedge clock) begin
      xtal_run <= opt.src == mcst_pkg::mcst_src_xtal;
   end

   always_ff @(posedge clock) begin
      if (rst)
         ext_pin_in_sel <= 1'b1;
      else
         ext_pin_in_sel <= opt.src == mcst_pkg::mcst_src_ext;
   end
endmodule

// File: rtl/mcst_params.svh
// constants for the clock source and trim block
`ifndef MCST_PARAMS_SVH
`define MCST_PARAMS_SVH
`define MCST_OFS_MAIN_CTRL    12'h000
`define MCST_OFS_TRIM_UPPER   12'h004
`define MCST_OFS_INTEGRITY    12'h008
`define MCST_OFS_STATUS       12'h00C
`define MCST_OFS_FTRIM        12'h010
`define MCST_MAIN_CTRL_RESET  8'h00
`define MCST_TRIM_UPPER_RESET 8'hFF
`define MCST_TRIM_LOW_RESET   2'h0
`define MCST_BIT_SLOW         0
`define MCST_BIT_CLKOUT       1
`define MCST_TRIM_LOW_LSB     5
`define MCST_TRIM_LOW_MSB     6
`define MCST_BIT_LOCK         0
`define MCST_BIT_PLL_RUN      1
`define MCST_SLOW_DIV         6'd32
`define MCST_STARTUP_US       20
`define MCST_LOCK_US          40
`define MCST_CLK_MHZ          25
`define MCST_STARTUP_CYC      (`MCST_STARTUP_US * `MCST_CLK_MHZ)
`define MCST_LOCK_CYC         (`MCST_LOCK_US * `MCST_CLK_MHZ)
`define MCST_FT_HIGH_5V       8'h80
`define MCST_FT_LOW_5V        8'h00
`define MCST_FT_HIGH_3V       8'h80
`define MCST_FT_LOW_3V        8'h00
`endif

// File: rtl/mcst_pkg.sv
// types for the clock source and trim block
package mcst_pkg;
   typedef enum logic [1:0] {
      mcst_src_ext,
      mcst_src_xtal,
      mcst_src_rc
   } mcst_src_t;
   typedef enum logic [1:0] {
      mcst_pll_off,
      mcst_pll_x4,
      mcst_pll_x8
   } mcst_pll_t;
   typedef struct packed {
      mcst_src_t  src;
      logic [2:0] osc_range_option;
      mcst_pll_t  pll_factor_option;
   } mcst_opt_t;
   typedef struct packed {
      logic       psel;
      logic       penable;
      logic       pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } mcst_apb_req_t;
endpackage

// File: rtl/mcst_ftrim_rom.sv
// factory trim storage, independent of user memory erase
`timescale 1ns/100ps
`include "mcst_params.svh"
module mcst_ftrim_rom (
   input  wire logic       clock,  // system clock
   input  wire logic [1:0] addr,   // byte index 0..3
   output logic      [7:0] rdata   // registered read byte
);
   // fixed contents, no erase path reaches them
   always_ff @(posedge clock) begin
      unique case (addr)
         2'd0: rdata <= `MCST_FT_HIGH_5V;
         2'd1: rdata <= `MCST_FT_LOW_5V;
         2'd2: rdata <= `MCST_FT_HIGH_3V;
         2'd3: rdata <= `MCST_FT_LOW_3V;
      endcase
   end
endmodule

// File: rtl/mcst_pll_ctrl.sv
// PLL start-up and lock sequencing
`timescale 1ns/100ps
`include "mcst_params.svh"
module mcst_pll_ctrl (
   input  wire logic clock,   // system clock
   input  wire logic rst,     // sync reset
   input  wire logic enable,  // PLL enabled by option
   input  wire logic wake,    // wake from halt pulse
   output logic      run,     // output clock released
   output logic      pll_lock_flag   // lock flag
);
   logic [11:0] cnt_q;
   always_ff @(posedge clock) begin
      if (rst || wake || !enable) begin
         cnt_q  <= 12'h000;
         run    <= 1'b0;
         pll_lock_flag <= 1'b0;
      end else begin
         if (cnt_q != 12'(`MCST_LOCK_CYC))
            cnt_q <= cnt_q + 12'h001;
         if (cnt_q == 12'(`MCST_STARTUP_CYC))
            run <= 1'b1;
         if (cnt_q == 12'(`MCST_LOCK_CYC))
            pll_lock_flag <= 1'b1;
      end
   end
endmodule

// File: verification/mcst_src_model.sv
// oscillator sources feeding the clock block
`timescale 1ns/100ps
module mcst_src_model #(parameter int XTAL_DIV = 3) (
   input  wire logic clock,        // system clock
   output logic      rc_tick,      // 1 MHz rc enable
   output logic      xtal_tick,    // crystal enable
   output logic      ext_clock_in  // 1 MHz external enable
);
   int n = 0;
   initial {rc_tick, xtal_tick, ext_clock_in} = 3'h0;
   // free running, reset does not stop a resonator
   always @(posedge clock) begin
      n <= n + 1;
      rc_tick <= (n % 25) == 0;
      xtal_tick <= (n % XTAL_DIV) == 0;
      ext_clock_in <= (n % 25) == 12;
   end
endmodule

// File: verification/mcst_clock_chk.sv
// port assertions for the clock block
`timescale 1ns/100ps
module mcst_clock_chk (
   input wire logic                clock,          // clock
   input wire logic                rst,            // reset
   input wire mcst_pkg::mcst_opt_t opt,            // options
   input wire logic                wake_halt,      // wake
   input wire logic                rc_tick,        // rc source
   input wire logic                ext_clock_in,   // ext source
   input wire logic                psel,           // apb select
   input wire logic                penable,        // apb enable
   input wire logic [11:0]         paddr,          // apb address
   input wire logic                pready,         // apb ready
   input wire logic                pslverr,        // apb error
   input wire logic                osc_tick,       // osc clock
   input wire logic                clk_out_pin,    // pin level
   input wire logic                clk_out_oe,     // pin drive
   input wire logic                ext_pin_in_sel, // ext pin select
   input wire logic [9:0]          rc_trim         // trim code
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   trim_reset_a: assert property ($fell(rst) |-> rc_trim == 10'h3fc && !clk_out_oe && !pready)
      else $error("reset values wrong");
   ready_late_a: assert property (psel && $rose(penable) |=> pready) else $error("pready not in time");
   ready_pulse_a: assert property (pready |=> !pready) else $error("pready stuck");
   unmapped_err_a: assert property (pready && paddr > 12'h01c |-> pslverr) else $error("no error");
   pin_gate_a: assert property (!clk_out_oe |-> !clk_out_pin) else $error("pin driven while off");
   ext_sel_a: assert property (!$past(rst) |-> ext_pin_in_sel == ($past(opt.src) == mcst_pkg::mcst_src_ext))
      else $error("ext pin select wrong");
   rc_direct_a: assert property (!$past(rst) && $past(opt) == opt && opt.src == mcst_pkg::mcst_src_rc
      && opt.pll_factor_option == mcst_pkg::mcst_pll_off |-> osc_tick == $past(rc_tick)) else $error("rc path");
   ext_direct_a: assert property (!$past(rst) && $past(opt) == opt && opt.src == mcst_pkg::mcst_src_ext
      && opt.pll_factor_option == mcst_pkg::mcst_pll_off |-> osc_tick == $past(ext_clock_in)) else $error("ext path");
   pll_hold_a: assert property (($fell(rst) || wake_halt) && opt.pll_factor_option != mcst_pkg::mcst_pll_off
      |=> ##2 !osc_tick [*6]) else $error("pll clock early");
endmodule
bind mcst_clock_top mcst_clock_chk u_chk (.clock(clock), .rst(rst), .opt(opt), .wake_halt(wake_halt),
   .rc_tick(rc_tick), .ext_clock_in(ext_clock_in), .psel(psel), .penable(penable), .paddr(paddr),
   .pready(pready), .pslverr(pslverr), .osc_tick(osc_tick), .clk_out_pin(clk_out_pin),
   .clk_out_oe(clk_out_oe), .ext_pin_in_sel(ext_pin_in_sel), .rc_trim(rc_trim));

// File: verification/tb_top.sv
// self-checking bench for the clock block
`timescale 1ns/100ps
`include "mcst_params.svh"
module tb_top;
   logic                clock = 0;
   logic                rst = 1;
   mcst_pkg::mcst_opt_t opt = '{mcst_pkg::mcst_src_rc, 3'h0, mcst_pkg::mcst_pll_off};
   logic                wake_halt = 0, psel = 0, penable = 0, pwrite = 0, er;
   logic [11:0]         paddr = 12'h000;
   logic [31:0]         pwdata = 32'h0000_0000, prdata, rd;
   logic                pready, pslverr, osc_tick, cpu_tick, clk_out_pin, clk_out_oe, ext_pin_in_sel, xtal_run;
   logic                rc_tick, xtal_tick, ext_clock_in;
   logic [9:0]          rc_trim;
   int                  err_total = 0, cmp_count = 0, cyc = 0, no, nc, np, ns, mc, tu, tl;
   int                  q[$] = '{8'h80, 8'h40, 8'h60, 8'h50};
   always #20 clock = ~clock;
   mcst_src_model SRC (.clock(clock), .rc_tick(rc_tick), .xtal_tick(xtal_tick), .ext_clock_in(ext_clock_in));
   mcst_clock_top DUT (.clock(clock), .rst(rst), .opt(opt), .wake_halt(wake_halt), .rc_tick(rc_tick),
      .xtal_tick(xtal_tick), .ext_clock_in(ext_clock_in), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_tick(osc_tick),
      .cpu_tick(cpu_tick), .clk_out_pin(clk_out_pin), .clk_out_oe(clk_out_oe), .ext_pin_in_sel(ext_pin_in_sel),
      .xtal_run(xtal_run), .rc_trim(rc_trim));
   task automatic tally_and_finish;
      if (err_total == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // slack of one tick: window edges cut pulses
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g, input int tol = 0);
      cmp_count++;
      if (g !== e && (tol == 0 || $signed(g - e) > tol || $signed(e - g) > tol)) begin
         err_total++;
         $display("mismatch %s exp %0h got %0h", n, e, g);
      end
   endtask
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_total++;
         tally_and_finish();
      end
   end
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clock);
   endtask
   task automatic regs;
      apb(0, `MCST_OFS_MAIN_CTRL, 0);
      chk("main_ctrl", mc, rd);
      apb(0, `MCST_OFS_TRIM_UPPER, 0);
      chk("trim_upper", tu, rd);
      apb(0, `MCST_OFS_INTEGRITY, 0);
      chk("integrity", tl << 5, rd & 32'h0000_0060);
      chk("rc_trim", {tu[7:0], tl[1:0]}, {22'h0, rc_trim});
   endtask
   task automatic reset_dut;
      rst <= 1;
      repeat (8) @(posedge clock);
      chk("xtal_run", opt.src == mcst_pkg::mcst_src_xtal, xtal_run);
      repeat (8) @(posedge clock);
      rst <= 0;
      mc = 0;
      tu = 255;
      tl = 0;
      @(posedge clock);
   endtask
   task automatic count(input int n);
      {no, nc, np, ns} = 0;
      repeat (n) begin
         @(posedge clock);
         no += osc_tick;
         nc += cpu_tick;
         np += clk_out_pin;
         ns += opt.src == mcst_pkg::mcst_src_ext ? ext_clock_in : opt.src == mcst_pkg::mcst_src_rc ? rc_tick : xtal_tick;
      end
   endtask
   task automatic src_run(input mcst_pkg::mcst_src_t s);
      opt.src <= s;
      reset_dut();
      count(500);
      chk("osc_ticks", ns, no, 1);
      chk("ext_sel", s == mcst_pkg::mcst_src_ext, ext_pin_in_sel);
   endtask
   task automatic pll_run(input mcst_pkg::mcst_pll_t f, input int e);
      opt <= '{mcst_pkg::mcst_src_rc, 3'h0, f};
      reset_dut();
      count(`MCST_STARTUP_CYC - 40);
      chk("pll_early", 0, no);
      repeat (1100) @(posedge clock);
      apb(0, `MCST_OFS_STATUS, 0);
      chk("lock", 1, rd[0]);
      chk("pll_running", 1, rd[1]);
      count(100);
      chk("pll_rate", e, no, 1);
      wake_halt <= 1;
      @(posedge clock);
      wake_halt <= 0;
      // a tick launched at the wake edge is still legal
      @(posedge clock);
      count(400);
      chk("wake_hold", 0, no);
   endtask
   initial begin
      void'($urandom(28588));
      reset_dut();
      regs();
      for (int i = 0; i < 8; i++) begin
         tu = i < 4 ? q[i] : $urandom % 256;
         tl = $urandom % 4;
         apb(1, `MCST_OFS_TRIM_UPPER, tu);
         apb(1, `MCST_OFS_INTEGRITY, tl << 5);
         regs();
      end
      for (int i = 0; i < 4; i++) begin
         apb(0, `MCST_OFS_FTRIM + 4 * i, 0);
         chk("factory", i == 0 ? `MCST_FT_HIGH_5V : i == 1 ? `MCST_FT_LOW_5V : i == 2 ? `MCST_FT_HIGH_3V
            : `MCST_FT_LOW_3V, rd & 32'h0000_00ff);
      end
      apb(1, 12'h020, 32'h0000_00ff);
      chk("unmapped", 1, er);
      apb(0, 12'h020, 0);
      chk("unmapped_rd", 0, rd);
      regs();
      mc = 2;
      apb(1, `MCST_OFS_MAIN_CTRL, mc);
      count(800);
      chk("cpu_fast", no, nc, 1);
      chk("pin", nc, np, 1);
      chk("oe", 1, clk_out_oe);
      mc = 3;
      apb(1, `MCST_OFS_MAIN_CTRL, mc);
      // slow mode only bites at the next divider wrap
      repeat (800) @(posedge clock);
      count(3200);
      chk("cpu_slow", no / 32, nc, 1);
      chk("pin_slow", nc, np, 1);
      regs();
      reset_dut();
      regs();
      src_run(mcst_pkg::mcst_src_ext);
      src_run(mcst_pkg::mcst_src_xtal);
      src_run(mcst_pkg::mcst_src_rc);
      pll_run(mcst_pkg::mcst_pll_x8, 100);
      pll_run(mcst_pkg::mcst_pll_x4, 50);
      tally_and_finish();
   end
endmodule
